//--- verilog/sarb_cfg.svh
`ifndef SARB_CFG_SVH
`define SARB_CFG_SVH

// register byte addresses
`define SARB_ADDR_MODE 8'h48
`define SARB_ADDR_STATUS 8'h60

// mode word field positions
`define SARB_EN_LSB 0
`define SARB_BIT_STRAP 9
`define SARB_BIT_BMTO 10
`define SARB_BIT_REFR 11
`define SARB_FAIR_LSB 12
`define SARB_FAIR_MSB 19
`define SARB_BIT_TOG 20
`define SARB_PRIO_LSB 22

// reset values
`define SARB_RST_EN 9'h1FF
`define SARB_RST_PRIO 9'h001
`define SARB_RST_FAIR 8'h08

// timing counts in bus clocks
`define SARB_BM_CYCLES 5'h10
`define SARB_TOG_WAIT 2'h2

// axi responses
`define SARB_AXI_OKAY 2'h0
`define SARB_AXI_SLVERR 2'h2

`endif

//--- verilog/sarb_pkg.sv
package sarb_pkg;

    typedef enum logic [1:0] {
        ARB_IDLE,
        ARB_GRANT,
        ARB_BUSY
    } sarb_state_t;

    typedef struct packed {
        logic aw_v;
        logic [7:0] aw_a;
        logic w_v;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic b_v;
        logic b_err;
        logic r_v;
        logic [31:0] r_d;
        logic r_err;
    } sarb_axil_st_t;

endpackage : sarb_pkg

//--- verilog/sarb_rr_pick.sv
`timescale 1ns/10ps
module sarb_rr_pick #(
    parameter int N = 9,
    parameter int IW = 4
) (
    input wire logic [N-1:0] mask, // candidate requesters
    input wire logic [IW-1:0] last, // index granted last
    output logic found, // some candidate present
    output logic [IW-1:0] idx // chosen candidate
);

    // search starts just after the last winner so equals rotate
    always_comb begin : pick
        int j;
        j = 0;
        found = 1'b0;
        idx = '0;
        for (int k = 1; k <= N; k++) begin
            j = (int'(last) + k) % N;
            if (!found && mask[j]) begin
                found = 1'b1;
                idx = IW'(j);
            end
        end
    end

endmodule : sarb_rr_pick

//--- verilog/sarb_axil_slave.sv
`timescale 1ns/10ps
`include "sarb_cfg.svh"
module sarb_axil_slave
    import sarb_pkg::*;
(
    input wire logic aclk, // bus clock
    input wire logic aresetn, // sync reset, low active
    input wire logic [7:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // byte enables
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [7:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    output logic reg_wr, // register write pulse
    output logic [7:0] reg_waddr, // register write address
    output logic [31:0] reg_wdata, // register write data
    output logic [3:0] reg_wstrb, // register write strobes
    input wire logic reg_whit, // write address mapped
    output logic [7:0] reg_raddr, // register read address
    input wire logic [31:0] reg_rdata, // register read data
    input wire logic reg_rhit // read address mapped
);

    sarb_axil_st_t q;
    sarb_axil_st_t d;

    assign awready = !q.aw_v && !q.b_v;
    assign wready = !q.w_v && !q.b_v;
    assign arready = !q.r_v;
    assign bvalid = q.b_v;
    assign bresp = q.b_err ? `SARB_AXI_SLVERR : `SARB_AXI_OKAY;
    assign rvalid = q.r_v;
    assign rdata = q.r_d;
    assign rresp = q.r_err ? `SARB_AXI_SLVERR : `SARB_AXI_OKAY;
    assign reg_wr = q.aw_v && q.w_v && !q.b_v;
    assign reg_waddr = q.aw_a;
    assign reg_wdata = q.w_d;
    assign reg_wstrb = q.w_s;
    assign reg_raddr = araddr;

    always_comb begin
        d = q;
        if (awvalid && awready) begin
            d.aw_v = 1'b1;
            d.aw_a = awaddr;
        end
        if (wvalid && wready) begin
            d.w_v = 1'b1;
            d.w_d = wdata;
            d.w_s = wstrb;
        end
        if (reg_wr) begin
            d.aw_v = 1'b0;
            d.w_v = 1'b0;
            d.b_v = 1'b1;
            d.b_err = !reg_whit;
        end
        if (q.b_v && bready) begin
            d.b_v = 1'b0;
        end
        if (arvalid && arready) begin
            d.r_v = 1'b1;
            d.r_d = reg_rdata;
            d.r_err = !reg_rhit;
        end else if (q.r_v && rready) begin
            d.r_v = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : sarb_axil_slave

//--- verilog/sarb_arbiter.sv
`timescale 1ns/10ps
`include "sarb_cfg.svh"

module sarb_arbiter
    import sarb_pkg::*;
#(
    parameter int N = 9,
    parameter int IW = 4
) (
    input wire logic aclk, // secondary bus clock
    input wire logic aresetn, // sync reset, low active
    input wire logic [7:0] awaddr, // axi write address
    input wire logic awvalid, // axi write address valid
    output logic awready, // axi write address ready
    input wire logic [31:0] wdata, // axi write data
    input wire logic [3:0] wstrb, // axi byte enables
    input wire logic wvalid, // axi write data valid
    output logic wready, // axi write data ready
    output logic [1:0] bresp, // axi write response
    output logic bvalid, // axi write response valid
    input wire logic bready, // axi write response ready
    input wire logic [7:0] araddr, // axi read address
    input wire logic arvalid, // axi read address valid
    output logic arready, // axi read address ready
    output logic [31:0] rdata, // axi read data
    output logic [1:0] rresp, // axi read response
    output logic rvalid, // axi read data valid
    input wire logic rready, // axi read data ready
    input wire logic arbiter_select_strap, // high selects an external arbiter
    input wire logic [N-1:0] req_n, // requests, bit 0 the bridge itself
    input wire logic frame_n, // bus frame, low active
    input wire logic irdy_n, // initiator ready, low active
    output logic [N-1:0] gnt_n // grants, low active
);

    typedef struct packed {
        sarb_state_t st;
        logic [IW-1:0] owner;
        logic [IW-1:0] last;
        logic [N-1:0] gnt;
        logic [7:0] fair;
        logic armed;
        logic [4:0] bm_cnt;
        logic [1:0] tog_cnt;
        logic frame_prev;
        logic [N-1:0] broken;
        logic [N-1:0] served;
        logic [N-1:0] en;
        logic [N-1:0] prio;
        logic strap;
        logic bmto;
        logic refr;
        logic [7:0] fair_ld;
        logic tog;
    } sarb_arb_st_t;

    sarb_arb_st_t q;
    sarb_arb_st_t d;

    logic reg_wr;
    logic [7:0] reg_waddr;
    logic [31:0] reg_wdata;
    logic [3:0] reg_wstrb;
    logic [7:0] reg_raddr;
    logic [31:0] reg_rdata;
    logic [31:0] mode_word;
    logic [31:0] status_word;
    logic [31:0] wword;
    logic [N-1:0] elig;
    logic [N-1:0] hi;
    logic [N-1:0] pick_mask;
    logic [N-1:0] others;
    logic pick_found;
    logic [IW-1:0] pick_idx;
    logic bus_idle;
    logic frame_fall;
    logic own_req;

    function automatic logic [N-1:0] onehot(input logic [IW-1:0] i);
        logic [N-1:0] v;
        v = '0;
        v[i] = 1'b1;
        return v;
    endfunction : onehot

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] v;
        v = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                v[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return v;
    endfunction : merge

    function automatic logic addr_hit(input logic [7:0] a);
        return (a == `SARB_ADDR_MODE) || (a == `SARB_ADDR_STATUS);
    endfunction : addr_hit

    sarb_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .reg_wr(reg_wr),
        .reg_waddr(reg_waddr),
        .reg_wdata(reg_wdata),
        .reg_wstrb(reg_wstrb),
        .reg_whit(addr_hit(reg_waddr)),
        .reg_raddr(reg_raddr),
        .reg_rdata(reg_rdata),
        .reg_rhit(addr_hit(reg_raddr))
    );

    sarb_rr_pick #(
        .N(N),
        .IW(IW)
    ) u_pick (
        .mask(pick_mask),
        .last(q.last),
        .found(pick_found),
        .idx(pick_idx)
    );

    assign gnt_n = ~q.gnt;

    // reserved bits 21 and 31 read as zero
    assign mode_word = {1'b0, q.prio, 1'b0, q.tog, q.fair_ld, q.refr, q.bmto, q.strap, q.en};
    assign status_word = {7'h00, q.broken, 7'h00, q.gnt};

    always_comb begin
        if (reg_raddr == `SARB_ADDR_MODE) begin
            reg_rdata = mode_word;
        end else if (reg_raddr == `SARB_ADDR_STATUS) begin
            reg_rdata = status_word;
        end else begin
            reg_rdata = 32'h0000_0000;
        end
    end

    always_comb begin
        d = q;
        wword = merge(mode_word, reg_wdata, reg_wstrb);
        bus_idle = frame_n && irdy_n;
        frame_fall = q.frame_prev && !frame_n;
        elig = ~req_n & q.en & ~q.broken;
        hi = elig & q.prio;
        pick_mask = (|hi) ? hi : elig;
        own_req = !req_n[q.owner];
        others = elig & ~onehot(q.owner);
        d.frame_prev = frame_n;

        case (q.st)
            ARB_IDLE: begin
                d.gnt = '0;
                if (pick_found && !q.strap) begin
                    d.st = ARB_GRANT;
                    d.owner = pick_idx;
                    d.last = pick_idx;
                    d.gnt = onehot(pick_idx);
                    d.fair = q.fair_ld;
                    d.armed = 1'b0;
                    d.bm_cnt = 5'h00;
                    d.tog_cnt = 2'h0;
                    d.served[pick_idx] = 1'b1;
                end
            end
            ARB_GRANT: begin
                // owner is expected to start its frame here
                if (!own_req) begin
                    d.st = ARB_IDLE;
                    d.gnt = '0;
                end else if (frame_fall) begin
                    d.st = ARB_BUSY;
                    d.armed = 1'b1;
                end else if (q.bmto && bus_idle) begin
                    d.bm_cnt = q.bm_cnt + 5'h01;
                    if (q.bm_cnt == `SARB_BM_CYCLES - 5'h01) begin
                        d.broken[q.owner] = 1'b1;
                        d.served = '0;
                        d.gnt = '0;
                        d.st = ARB_IDLE;
                    end
                end
            end
            ARB_BUSY: begin
                d.gnt = onehot(q.owner);
                if (q.tog_cnt != 2'h3) begin
                    d.tog_cnt = q.tog_cnt + 2'h1;
                end
                if (q.tog && q.tog_cnt == `SARB_TOG_WAIT - 2'h1) begin
                    d.gnt = '0;
                end
                if (!own_req) begin
                    d.st = ARB_IDLE;
                    d.gnt = '0;
                end else if (q.fair_ld != 8'h00 && q.armed && |others) begin
                    // counter runs only while someone else is waiting
                    if (q.fair == 8'h00) begin
                        d.st = ARB_IDLE;
                        d.gnt = '0;
                    end else begin
                        d.fair = q.fair - 8'h01;
                    end
                end
            end
            default: begin
                d.st = ARB_IDLE;
                d.gnt = '0;
            end
        endcase

        // an external arbiter owns the bus: grant nobody
        if (q.strap) begin
            d.st = ARB_IDLE;
            d.gnt = '0;
        end

        // refresh clears only marks present before this cycle, so a new mark is kept
        if (q.refr && |q.broken && ((q.en & ~q.broken & ~q.served) == '0)) begin
            d.broken = d.broken & ~q.broken;
            // a grant made in the same cycle loses its served mark, since its bit was already set
            d.served = d.served & ~q.served;
        end

        if (reg_wr && reg_waddr == `SARB_ADDR_MODE) begin
            d.en = wword[`SARB_EN_LSB +: N];
            d.bmto = wword[`SARB_BIT_BMTO];
            d.refr = wword[`SARB_BIT_REFR];
            d.fair_ld = wword[`SARB_FAIR_MSB:`SARB_FAIR_LSB];
            d.tog = wword[`SARB_BIT_TOG];
            d.prio = wword[`SARB_PRIO_LSB +: N];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.frame_prev <= 1'b1;
            q.en <= `SARB_RST_EN;
            q.prio <= `SARB_RST_PRIO;
            q.fair_ld <= `SARB_RST_FAIR;
            q.strap <= arbiter_select_strap;
        end else begin
            q <= d;
        end
    end

endmodule : sarb_arbiter

//--- sim/sarb_arbiter_asserts.sv
`timescale 1ns/10ps
module sarb_arbiter_asserts #(
    parameter int N = 9
) (
    input wire logic aclk, // bus clock
    input wire logic aresetn, // sync reset, low active
    input wire logic awvalid, // write address valid
    input wire logic awready, // write address ready
    input wire logic wvalid, // write data valid
    input wire logic wready, // write data ready
    input wire logic [1:0] bresp, // write response
    input wire logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic arvalid, // read address valid
    input wire logic arready, // read address ready
    input wire logic [1:0] rresp, // read response
    input wire logic [31:0] rdata, // read data
    input wire logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic arbiter_select_strap, // arbiter select strap
    input wire logic [N-1:0] req_n, // requests, low active
    input wire logic [N-1:0] gnt_n // grants, low active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence rd_take;
        arvalid && arready;
    endsequence
    sequence wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence new_gnt;
        (~gnt_n & $past(gnt_n)) != '0;
    endsequence
    gnt_onehot_a: assert property ($onehot0(~gnt_n)) else $error("two grants at once");
    strap_blocks_a: assert property (arbiter_select_strap |-> gnt_n == '1) else $error("grant under strap");
    rd_answer_a: assert property (rd_take |=> rvalid && !arready) else $error("read not answered");
    rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer moved");
    wr_answer_a: assert property (wr_take |-> ##2 bvalid) else $error("write not answered");
    wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write answer moved");
    gnt_cause_a: assert property (new_gnt |-> (~gnt_n & $past(req_n)) == '0)
        else $error("grant without request");
    release_drop_a: assert property ((~gnt_n & req_n) != '0 |=> (~gnt_n & $past(~gnt_n & req_n)) == '0)
        else $error("grant kept after release");
    gnt_gap_a: assert property ($past(gnt_n) != '1 && gnt_n != '1 |-> gnt_n == $past(gnt_n))
        else $error("handoff without idle cycle");
endmodule : sarb_arbiter_asserts

bind sarb_arbiter sarb_arbiter_asserts #(.N(N)) chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rresp(rresp), .rdata(rdata), .rvalid(rvalid), .rready(rready),
    .arbiter_select_strap(arbiter_select_strap), .req_n(req_n), .gnt_n(gnt_n));

//--- sim/sarb_master_model.sv
`timescale 1ns/10ps
module sarb_master_model (
    input wire logic aclk, // bus clock
    input wire logic [8:0] want, // masters asking for the bus
    input wire logic [8:0] dead, // masters that never start a frame
    input wire logic [8:0] gnt_n, // grants, low active
    output logic [8:0] req_n, // requests, low active
    output logic frame_n, // frame, low active
    output logic irdy_n // initiator ready, low active
);
    logic [3:0] left;
    initial begin
        {frame_n, irdy_n, left} = 6'h30;
    end
    assign req_n = ~want;
    // five data phases, then frame and irdy released to their pull-up level
    always @(posedge aclk) begin
        if (left != 4'h0) begin
            left <= left - 4'h1;
            frame_n <= (left <= 4'h2);
            irdy_n <= (left == 4'h1);
        end else if ((~gnt_n & ~dead) != 9'h000 && frame_n && irdy_n) begin
            left <= 4'h5;
            frame_n <= 1'b0;
            irdy_n <= 1'b0;
        end
    end
endmodule : sarb_master_model

//--- sim/sarb_arbiter_bench.sv
`timescale 1ns/10ps
module sarb_arbiter_bench;
    typedef struct packed {
        logic wr;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0] r;
    } sarb_row_t;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, strap, frame_n, irdy_n;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rr;
    logic [8:0] want, dead, req_n, gnt_n;
    int miscompares = 0, total_checks = 0, n;
    sarb_row_t rows [5] = '{'{1'b0, 8'h48, 32'h0, 32'h004081FF, 2'h0}, '{1'b1, 8'h48, 32'hFFFFFFFF,
        32'h7FDFFDFF, 2'h0}, '{1'b1, 8'h48, 32'h004081FF, 32'h004081FF, 2'h0},
        '{1'b0, 8'h60, 32'h0, 32'h0, 2'h0}, '{1'b1, 8'h44, 32'hFFFFFFFF, 32'h0, 2'h2}};
    always #50 aclk = ~aclk;
    sarb_arbiter uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .arbiter_select_strap(strap), .req_n(req_n), .frame_n(frame_n),
        .irdy_n(irdy_n), .gnt_n(gnt_n));
    sarb_master_model pm (.aclk(aclk), .want(want), .dead(dead), .gnt_n(gnt_n), .req_n(req_n),
        .frame_n(frame_n), .irdy_n(irdy_n));
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, ta, tw;
        {aw, w} = 2'h3;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        while (aw | w) begin
            @(negedge aclk);
            {ta, tw} = {awready, wready};
            @(posedge aclk);
            if (aw & ta) awvalid <= 1'b0;
            if (w & tw) wvalid <= 1'b0;
            {aw, w} = {aw & ~ta, w & ~tw};
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        {d, r} = {rdata, rresp};
        @(posedge aclk);
        rready <= 1'b0;
    endtask : axr
    task automatic setm(input logic [31:0] d);
        axw(8'h48, d, rr);
        check("bresp", rr, 2'h0);
    endtask : setm
    task automatic rst(input logic s);
        @(posedge aclk);
        {aresetn, strap} <= {1'b0, s};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
    endtask : rst
    task automatic wnt(input logic [8:0] v);
        @(posedge aclk);
        want <= v;
    endtask : wnt
    task automatic gw(input logic [8:0] e);
        int i;
        i = 0;
        @(negedge aclk);
        while (gnt_n !== 9'h1FF && i < 60) begin
            @(negedge aclk);
            i++;
        end
        while (gnt_n === 9'h1FF && i < 120) begin
            @(negedge aclk);
            i++;
        end
        check("grant", gnt_n, 9'(~e));
    endtask : gw
    // counts grant cycles, from the grant or from the first frame cycle
    task automatic hc(input logic ff, output int c);
        c = 0;
        if (ff) while (frame_n !== 1'b0) @(negedge aclk);
        while (gnt_n !== 9'h1FF && c < 99) begin
            c++;
            @(negedge aclk);
        end
    endtask : hc
    task automatic quiet(input int c);
        repeat (c) @(negedge aclk);
        check("idle", gnt_n, 9'h1FF);
    endtask : quiet
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, strap} = 8'h0;
        {awaddr, araddr, wdata, want, dead} = '0;
        rst(1'b0);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axw(rows[i].a, rows[i].d, rr);
                check("bresp", rr, rows[i].r);
            end
            axr(rows[i].a, rd, rr);
            check("rdata", rd, rows[i].e);
            check("rresp", rr, rows[i].r);
        end
        wnt(9'h005);
        gw(9'h001);
        wnt(9'h004);
        gw(9'h004);
        setm(32'h000001FF);
        wnt(9'h00A);
        gw(9'h008);
        repeat (30) @(negedge aclk);
        check("hold", gnt_n, 9'h1F7);
        wnt(9'h006);
        gw(9'h002);
        wnt(9'h004);
        gw(9'h004);
        wnt(9'h000);
        setm(32'h000021FF);
        wnt(9'h030);
        gw(9'h010);
        hc(1'b1, n);
        check("fair", n, 4);
        @(negedge aclk);
        check("regrant", gnt_n, 9'h1DF);
        hc(1'b1, n);
        check("refair", n, 4);
        wnt(9'h000);
        setm(32'h001001FF);
        wnt(9'h040);
        gw(9'h040);
        do @(negedge aclk); while (frame_n !== 1'b0);
        for (int k = 0; k < 5; k++) begin
            check("toggle", gnt_n[6], k == 3);
            @(negedge aclk);
        end
        wnt(9'h000);
        setm(32'h000005FF);
        dead <= 9'h080;
        wnt(9'h080);
        gw(9'h080);
        hc(1'b0, n);
        check("timeout", n, 16);
        wnt(9'h000);
        wnt(9'h180);
        gw(9'h100);
        wnt(9'h080);
        quiet(40);
        axr(8'h60, rd, rr);
        check("status", rd, 32'h00800000);
        dead <= 9'h000;
        setm(32'h00000D80);
        wnt(9'h100);
        gw(9'h100);
        wnt(9'h080);
        gw(9'h080);
        wnt(9'h000);
        setm(32'h000001FD);
        wnt(9'h002);
        quiet(30);
        rst(1'b1);
        axr(8'h48, rd, rr);
        check("strap", rd, 32'h004083FF);
        quiet(20);
        conclude();
    end
    initial begin
        #4000000;
        miscompares++;
        conclude();
    end
endmodule : sarb_arbiter_bench
